/* File: design/sws_link.sv */
`timescale 1ns/1ps
module sws_link #(
	parameter int TICK_DIV = sws_pkg::TICK_CYC
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic line_in,
	output logic line_out,
	output logic line_oe_out,
	input wire logic [63:0] rom_code_in,
	input wire logic tx_en_in,
	input wire logic tx_bit_in,
	output logic slot_start_out,
	output logic rx_bit_out,
	output logic rx_valid_out,
	output logic selected_out,
	output logic fast_speed_flag_out,
	output logic link_reset_out
);
	localparam int CW = sws_pkg::CW;

	sws_pkg::sws_state_t state_reg;
	logic line_s;
	logic line_d_reg;
	logic fall;
	logic rise;
	logic tick;
	logic fast;
	logic fast_speed_flag_reg;
	logic match_fast_reg;
	logic low_fast_reg;
	logic [CW-1:0] low_cnt_reg;
	logic [CW-1:0] tmr_reg;
	logic [CW-1:0] slot_tmr_reg;
	logic slot_act_reg;
	logic drive_zero_reg;
	logic pres_drive;
	logic bus_reset;
	logic in_pres;
	logic sample_now;
	logic hold_end;
	logic [7:0] cmd_reg;
	logic [7:0] cmd_full;
	logic [5:0] bit_cnt_reg;
	logic mism_reg;
	logic rom_bit;

	// Pick a standard or fast figure according to the current speed
	function automatic logic [CW-1:0] pick(input logic f,
		input logic [CW-1:0] std_v, input logic [CW-1:0] fast_v);
		pick = f ? fast_v : std_v;
	endfunction

	sws_sync u_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.async_in(line_in),
		.sync_out(line_s)
	);

	sws_tick #(
		.DIV(TICK_DIV)
	) u_tick (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.restart_in(fall | rise),
		.tick_out(tick)
	);

	// Edge detection works only on the synchronised level
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			line_d_reg <= 1'b1;
		end else begin
			line_d_reg <= line_s;
		end
	end

	assign fall = line_d_reg & ~line_s;
	assign rise = ~line_d_reg & line_s;

	// Fast timing also covers the ROM bits that follow a fast-match code
	assign fast = fast_speed_flag_reg | match_fast_reg;
	assign in_pres = (state_reg == sws_pkg::ST_PRES_WAIT) ||
		(state_reg == sws_pkg::ST_PRES_LOW);

	// Low-time meter; cleared while we pull so our own pulses never count
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			low_cnt_reg <= '0;
		end else if (fall || line_oe_out) begin
			low_cnt_reg <= '0;
		end else if (!line_s && tick && low_cnt_reg != sws_pkg::CNT_MAX) begin
			low_cnt_reg <= low_cnt_reg + 1'b1;
		end
	end

	// Speed in force when the line went low; a command that switches speed
	// at its last sample must not turn the rest of that slot into a reset
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			low_fast_reg <= 1'b0;
		end else if (fall) begin
			low_fast_reg <= fast;
		end
	end

	// A long enough low ended by a rise is a bus reset, fast or standard
	assign bus_reset = rise && !in_pres && (low_cnt_reg >= pick(low_fast_reg,
		sws_pkg::RST_STD_MIN_TK, sws_pkg::RST_FAST_MIN_TK));

	// Presence pulse is the only falling edge this end creates
	assign pres_drive = (state_reg == sws_pkg::ST_PRES_LOW);

	// Slot timer started by the master's falling edge
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			slot_act_reg <= 1'b0;
			slot_tmr_reg <= '0;
		end else if (bus_reset) begin
			slot_act_reg <= 1'b0;
			slot_tmr_reg <= '0;
		end else if (fall && !in_pres && !slot_act_reg) begin
			slot_act_reg <= 1'b1;
			slot_tmr_reg <= '0;
		end else if (slot_act_reg && hold_end) begin
			slot_act_reg <= 1'b0;
			slot_tmr_reg <= '0;
		end else if (slot_act_reg && tick) begin
			slot_tmr_reg <= slot_tmr_reg + 1'b1;
		end
	end

	// Sample and release points are ticks counted from the falling edge
	assign sample_now = slot_act_reg && tick && (slot_tmr_reg == pick(fast,
		sws_pkg::SAMPLE_STD_TK, sws_pkg::SAMPLE_FAST_TK) - 1'b1);
	assign hold_end = tick && (slot_tmr_reg >= pick(fast,
		sws_pkg::HOLD_STD_TK, sws_pkg::HOLD_FAST_TK) - 1'b1);

	// Read-zero pulldown; the bit is taken at the slot's falling edge
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			drive_zero_reg <= 1'b0;
		end else if (bus_reset) begin
			drive_zero_reg <= 1'b0;
		end else if (fall && !in_pres && !slot_act_reg) begin
			drive_zero_reg <= (state_reg == sws_pkg::ST_FUNC) &&
				tx_en_in && !tx_bit_in;
		end else if (slot_act_reg && hold_end) begin
			drive_zero_reg <= 1'b0;
		end
	end

	// Open drain: the pin is only ever pulled low, never driven high
	assign line_out = 1'b0;
	assign line_oe_out = pres_drive | drive_zero_reg;
	assign slot_start_out = fall && !in_pres && !slot_act_reg &&
		(state_reg == sws_pkg::ST_FUNC);

	// Bits arrive least significant first
	assign cmd_full = {line_s, cmd_reg[7:1]};
	assign rom_bit = rom_code_in[bit_cnt_reg];

	// Link sequencer: reset, presence, command, match, function phase
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= sws_pkg::ST_WAIT_RST;
			tmr_reg <= '0;
			cmd_reg <= 8'h00;
			bit_cnt_reg <= 6'h00;
			mism_reg <= 1'b0;
		end else if (bus_reset) begin
			state_reg <= sws_pkg::ST_PRES_WAIT;
			tmr_reg <= '0;
			bit_cnt_reg <= 6'h00;
			mism_reg <= 1'b0;
		end else begin
			unique case (state_reg)
			sws_pkg::ST_WAIT_RST, sws_pkg::ST_IDLE: begin
				tmr_reg <= '0;
			end
			sws_pkg::ST_PRES_WAIT: begin
				if (tick && tmr_reg >= pick(fast, sws_pkg::PRES_WAIT_STD_TK,
					sws_pkg::PRES_WAIT_FAST_TK) - 1'b1) begin
					state_reg <= sws_pkg::ST_PRES_LOW;
					tmr_reg <= '0;
				end else if (tick) begin
					tmr_reg <= tmr_reg + 1'b1;
				end
			end
			sws_pkg::ST_PRES_LOW: begin
				if (tick && tmr_reg >= pick(fast, sws_pkg::PRES_LOW_STD_TK,
					sws_pkg::PRES_LOW_FAST_TK) - 1'b1) begin
					state_reg <= sws_pkg::ST_ROM_CMD;
					tmr_reg <= '0;
				end else if (tick) begin
					tmr_reg <= tmr_reg + 1'b1;
				end
			end
			sws_pkg::ST_ROM_CMD: begin
				if (sample_now) begin
					cmd_reg <= cmd_full;
					bit_cnt_reg <= bit_cnt_reg + 1'b1;
					if (bit_cnt_reg == 6'(sws_pkg::CMD_BITS - 1)) begin
						bit_cnt_reg <= 6'h00;
						if (cmd_full == sws_pkg::CMD_SKIP ||
							cmd_full == sws_pkg::CMD_FAST_SKIP) begin
							state_reg <= sws_pkg::ST_FUNC;
						end else if (cmd_full == sws_pkg::CMD_FAST_MATCH) begin
							state_reg <= sws_pkg::ST_MATCH;
						end else begin
							state_reg <= sws_pkg::ST_IDLE;
						end
					end
				end
			end
			sws_pkg::ST_MATCH: begin
				if (sample_now) begin
					bit_cnt_reg <= bit_cnt_reg + 1'b1;
					mism_reg <= mism_reg | (line_s != rom_bit);
					if (bit_cnt_reg == 6'(sws_pkg::ROM_BITS - 1)) begin
						if (!mism_reg && line_s == rom_bit) begin
							state_reg <= sws_pkg::ST_FUNC;
						end else begin
							state_reg <= sws_pkg::ST_IDLE;
						end
					end
				end
			end
			sws_pkg::ST_FUNC: begin
				tmr_reg <= '0;
			end
			default: begin
				state_reg <= sws_pkg::ST_WAIT_RST;
			end
			endcase
		end
	end

	// Fast speed flag; a set from a command can never meet a clear here
	// because both sit on different bus events
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fast_speed_flag_reg <= 1'b0;
		end else if (bus_reset) begin
			if (low_cnt_reg >= sws_pkg::RST_CLEAR_MIN_TK) begin
				fast_speed_flag_reg <= 1'b0;
			end else if (low_cnt_reg <= sws_pkg::RST_KEEP_MAX_TK) begin
				fast_speed_flag_reg <= fast_speed_flag_reg;
			end else begin
				// Middle band is undefined; keeping the flag is simplest
				fast_speed_flag_reg <= fast_speed_flag_reg;
			end
		end else if (sample_now && state_reg == sws_pkg::ST_ROM_CMD &&
			bit_cnt_reg == 6'(sws_pkg::CMD_BITS - 1) &&
			cmd_full == sws_pkg::CMD_FAST_SKIP) begin
			fast_speed_flag_reg <= 1'b1;
		end else if (sample_now && state_reg == sws_pkg::ST_MATCH &&
			bit_cnt_reg == 6'(sws_pkg::ROM_BITS - 1) &&
			!mism_reg && line_s == rom_bit) begin
			fast_speed_flag_reg <= 1'b1;
		end
		// A mismatch never clears the flag, so earlier fast slaves stay fast
	end

	// Fast timing for the ROM bits after a fast-match code; kept until the
	// next reset so a losing slave still sees a fast reset pulse
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			match_fast_reg <= 1'b0;
		end else if (bus_reset) begin
			match_fast_reg <= 1'b0;
		end else if (sample_now && state_reg == sws_pkg::ST_ROM_CMD &&
			bit_cnt_reg == 6'(sws_pkg::CMD_BITS - 1) &&
			cmd_full == sws_pkg::CMD_FAST_MATCH) begin
			match_fast_reg <= 1'b1;
		end
	end

	// Function-phase bit delivery and status outputs
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_bit_out <= 1'b0;
			rx_valid_out <= 1'b0;
			link_reset_out <= 1'b0;
			selected_out <= 1'b0;
		end else begin
			rx_valid_out <= sample_now && state_reg == sws_pkg::ST_FUNC;
			if (sample_now && state_reg == sws_pkg::ST_FUNC) begin
				rx_bit_out <= line_s;
			end
			link_reset_out <= bus_reset;
			selected_out <= !bus_reset && (state_reg == sws_pkg::ST_FUNC ||
				(sample_now && (state_reg == sws_pkg::ST_ROM_CMD ||
				state_reg == sws_pkg::ST_MATCH) && selected_out));
			if (state_reg == sws_pkg::ST_FUNC) begin
				selected_out <= !bus_reset;
			end
		end
	end

	assign fast_speed_flag_out = fast_speed_flag_reg;

endmodule

/* File: inc/sws_pkg.sv */
package sws_pkg;

	// Clock and base tick: all link timing is counted in 1 us ticks
	localparam int CLK_MHZ = 100;
	localparam int TICK_US = 1;
	localparam int TICK_CYC = CLK_MHZ * TICK_US;
	localparam int CW = 10;

	// Reset pulse limits, in microseconds
	localparam int RST_STD_MIN_US = 120;
	localparam int RST_FAST_MIN_US = 16;
	localparam int RST_KEEP_MAX_US = 80;
	localparam int RST_CLEAR_MIN_US = 480;

	// Presence pulse timing, in microseconds
	localparam int PRES_WAIT_STD_US = 30;
	localparam int PRES_WAIT_FAST_US = 3;
	localparam int PRES_LOW_STD_US = 120;
	localparam int PRES_LOW_FAST_US = 12;

	// Slot timer: write sample point and read-zero release point
	localparam int SAMPLE_STD_US = 30;
	localparam int SAMPLE_FAST_US = 4;
	localparam int HOLD_STD_US = 30;
	localparam int HOLD_FAST_US = 4;

	// Same figures as tick counts at the width of the counters
	localparam logic [CW-1:0] RST_STD_MIN_TK = CW'(RST_STD_MIN_US / TICK_US);
	localparam logic [CW-1:0] RST_FAST_MIN_TK = CW'(RST_FAST_MIN_US / TICK_US);
	localparam logic [CW-1:0] RST_KEEP_MAX_TK = CW'(RST_KEEP_MAX_US / TICK_US);
	localparam logic [CW-1:0] RST_CLEAR_MIN_TK =
		CW'(RST_CLEAR_MIN_US / TICK_US);
	localparam logic [CW-1:0] PRES_WAIT_STD_TK =
		CW'(PRES_WAIT_STD_US / TICK_US);
	localparam logic [CW-1:0] PRES_WAIT_FAST_TK =
		CW'(PRES_WAIT_FAST_US / TICK_US);
	localparam logic [CW-1:0] PRES_LOW_STD_TK = CW'(PRES_LOW_STD_US / TICK_US);
	localparam logic [CW-1:0] PRES_LOW_FAST_TK =
		CW'(PRES_LOW_FAST_US / TICK_US);
	localparam logic [CW-1:0] SAMPLE_STD_TK = CW'(SAMPLE_STD_US / TICK_US);
	localparam logic [CW-1:0] SAMPLE_FAST_TK = CW'(SAMPLE_FAST_US / TICK_US);
	localparam logic [CW-1:0] HOLD_STD_TK = CW'(HOLD_STD_US / TICK_US);
	localparam logic [CW-1:0] HOLD_FAST_TK = CW'(HOLD_FAST_US / TICK_US);
	localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};

	// Address-level command codes and frame sizes
	localparam logic [7:0] CMD_SKIP = 8'hCC;
	localparam logic [7:0] CMD_FAST_SKIP = 8'h3C;
	localparam logic [7:0] CMD_FAST_MATCH = 8'h69;
	localparam int CMD_BITS = 8;
	localparam int ROM_BITS = 64;

	// Link states
	typedef enum logic [2:0] {
		ST_WAIT_RST = 3'b000,
		ST_PRES_WAIT = 3'b001,
		ST_PRES_LOW = 3'b010,
		ST_ROM_CMD = 3'b011,
		ST_MATCH = 3'b100,
		ST_FUNC = 3'b101,
		ST_IDLE = 3'b110
	} sws_state_t;

endpackage

/* File: design/sws_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for a pin; idle level of the bus is high
module sws_sync (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_reg <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

/* File: design/sws_tick.sv */
`timescale 1ns/1ps
// Microsecond tick divider; restart re-phases it to a line edge
module sws_tick #(
	parameter int DIV = sws_pkg::TICK_CYC
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic restart_in,
	output logic tick_out
);
	localparam int DW = $clog2(DIV + 1);
	localparam logic [DW-1:0] LAST = DW'(DIV - 1);
	logic [DW-1:0] div_reg;

	// Restarting on an edge removes up to a tick of slot timing jitter
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_reg <= '0;
			tick_out <= 1'b0;
		end else if (restart_in) begin
			div_reg <= '0;
			tick_out <= 1'b0;
		end else if (div_reg == LAST) begin
			div_reg <= '0;
			tick_out <= 1'b1;
		end else begin
			div_reg <= div_reg + 1'b1;
			tick_out <= 1'b0;
		end
	end
endmodule

/* File: verification/sws_link_props.sv */
`timescale 1ns/1ps
// Port-level checks for the link; only the pulldown length limit in clocks scales with TICK_DIV
module sws_link_props #(
	parameter int TICK_DIV = 100
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic line_in,
	input wire logic line_out,
	input wire logic line_oe_out,
	input wire logic [63:0] rom_code_in,
	input wire logic tx_en_in,
	input wire logic tx_bit_in,
	input wire logic slot_start_out,
	input wire logic rx_bit_out,
	input wire logic rx_valid_out,
	input wire logic selected_out,
	input wire logic fast_speed_flag_out,
	input wire logic link_reset_out
);
	logic [15:0] oe_run;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	// Length of the current pulldown; a stuck pulldown would hang the bus
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			oe_run <= 16'h0000;
		end else if (line_oe_out) begin
			oe_run <= oe_run + 16'h0001;
		end else begin
			oe_run <= 16'h0000;
		end
	end

	a_pin_open_drain: assert property (line_out == 1'b0)
		else $error("line value not low");
	a_presence_delay: assert property (
		link_reset_out |-> !line_oe_out [*8])
		else $error("pulldown too soon after reset");
	a_oe_bounded: assert property (oe_run <= 16'(122 * TICK_DIV))
		else $error("pulldown too long");
	a_rx_single: assert property (rx_valid_out |=> !rx_valid_out)
		else $error("rx valid longer than one cycle");
	a_rx_selected: assert property (rx_valid_out |-> selected_out)
		else $error("rx valid while not selected");
	a_reset_single: assert property (link_reset_out |=> !link_reset_out)
		else $error("reset pulse too long");
	a_reset_deselect: assert property (
		link_reset_out |-> ##2 !selected_out)
		else $error("still selected after bus reset");
	a_flag_clear_cause: assert property ($fell(fast_speed_flag_out) |->
		link_reset_out || $past(link_reset_out) || $past(link_reset_out, 2))
		else $error("fast flag cleared without bus reset");
	a_slot_selected: assert property (slot_start_out |-> selected_out)
		else $error("slot start outside function phase");
	a_read_zero_pull: assert property (
		slot_start_out && tx_en_in && !tx_bit_in |-> ##[1:3] line_oe_out)
		else $error("read zero not pulled low");
	a_read_one_quiet: assert property (
		slot_start_out && tx_en_in && tx_bit_in |-> !line_oe_out [*4])
		else $error("read one pulled low");
endmodule

bind sws_link sws_link_props #(.TICK_DIV(TICK_DIV)) u_props (.clk_in,
	.rst_b_in, .line_in, .line_out, .line_oe_out, .rom_code_in, .tx_en_in,
	.tx_bit_in, .slot_start_out, .rx_bit_out, .rx_valid_out, .selected_out,
	.fast_speed_flag_out, .link_reset_out);

/* File: verification/sws_link_mst.sv */
`timescale 1ns/1ps
// Bus master model; U clocks make one device microsecond
module sws_link_mst #(
	parameter int U = 100
) (
	input wire logic clk_in,
	input wire logic line_in,
	output logic pull_low_out
);
	// Released bus idles high through the pull-up
	initial pull_low_out = 1'b0;

	task automatic wait_us(input int n);
		repeat (n * U) @(posedge clk_in);
	endtask

	// Reset pulse, presence sample, then a reset-high window long enough
	// for a bus shared with other slave types
	task automatic bus_reset(input int low_us, input bit fast,
		output logic pres);
		pull_low_out <= 1'b1;
		wait_us(low_us);
		pull_low_out <= 1'b0;
		wait_us(fast ? 8 : 70);
		pres = line_in;
		wait_us(fast ? 40 : 410);
	endtask

	// One slot; a read is a write-one slot sampled early
	task automatic slot(input bit fast, input bit wbit, output logic rd);
		pull_low_out <= 1'b1;
		wait_us(fast ? 1 : 5);
		if (wbit) pull_low_out <= 1'b0;
		wait_us(fast ? 1 : 10);
		rd = line_in;
		wait_us(fast ? 6 : 45);
		pull_low_out <= 1'b0;
		wait_us(fast ? 3 : 10);
	endtask

	// Bits go out least significant first
	task automatic send(input logic [63:0] v, input int n, input bit fast);
		logic r;
		for (int i = 0; i < n; i++) slot(fast, v[i], r);
	endtask
endmodule

/* File: verification/sws_link_tb_top.sv */
`timescale 1ns/1ps
// Link bench: a master model on the wire, bench drives the user side
module sws_link_tb_top;
	localparam int DIV = 5;
	localparam logic [63:0] ROM = 64'hA1B2C3D4E5F60718;
	logic clk_in, rst_b_in, tx_en_in, tx_bit_in, mst_low;
	logic line_out, line_oe_out, slot_start_out, rx_bit_out, rx_valid_out;
	logic selected_out, fast_speed_flag_out, link_reset_out;
	wire line;
	int mismatches, checks;
	logic rxq[$];

	// Wired-AND of both pulldowns against the pull-up
	assign line = (line_oe_out ? line_out : 1'b1) & ~mst_low;

	sws_link #(.TICK_DIV(DIV)) u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.line_in(line), .line_out(line_out), .line_oe_out(line_oe_out),
		.rom_code_in(ROM), .tx_en_in(tx_en_in), .tx_bit_in(tx_bit_in),
		.slot_start_out(slot_start_out), .rx_bit_out(rx_bit_out),
		.rx_valid_out(rx_valid_out), .selected_out(selected_out),
		.fast_speed_flag_out(fast_speed_flag_out),
		.link_reset_out(link_reset_out));
	sws_link_mst #(.U(DIV)) u_mst (.clk_in(clk_in), .line_in(line),
		.pull_low_out(mst_low));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Collect every bit the device takes in the function phase
	always @(posedge clk_in) begin
		if (rx_valid_out === 1'b1) rxq.push_back(rx_bit_out);
	end

	task chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task conclude;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Reset with presence check, then one command byte
	task start(input int low_us, input bit fast, input logic [7:0] cmd);
		logic p;
		u_mst.bus_reset(low_us, fast, p);
		chk(p, 1'b0);
		u_mst.send(64'(cmd), 8, fast);
	endtask

	// Write a byte, then read a zero and a one
	task io_check(input bit fast);
		logic [7:0] b;
		logic r;
		rxq.delete();
		u_mst.send(64'hA5, 8, fast);
		chk(rxq.size(), 8);
		b = 8'h00;
		foreach (rxq[i]) b = {rxq[i], b[7:1]};
		chk(b, 8'hA5);
		for (int i = 0; i < 2; i++) begin
			tx_en_in <= 1'b1;
			tx_bit_in <= i[0];
			@(posedge clk_in);
			u_mst.slot(fast, 1'b1, r);
			chk(r, i[0]);
		end
		tx_en_in <= 1'b0;
	endtask

	task t_skip;
		start(500, 1'b0, sws_pkg::CMD_SKIP);
		chk(selected_out, 1'b1);
		chk(fast_speed_flag_out, 1'b0);
		io_check(1'b0);
		$display("test skip done");
	endtask

	task t_fast_skip;
		start(500, 1'b0, sws_pkg::CMD_FAST_SKIP);
		chk(fast_speed_flag_out, 1'b1);
		chk(selected_out, 1'b1);
		io_check(1'b1);
		start(50, 1'b1, sws_pkg::CMD_SKIP);
		chk(fast_speed_flag_out, 1'b1);
		start(500, 1'b0, sws_pkg::CMD_SKIP);
		chk(fast_speed_flag_out, 1'b0);
		$display("test fast skip done");
	endtask

	task t_match;
		start(500, 1'b0, sws_pkg::CMD_FAST_MATCH);
		u_mst.send(ROM, 64, 1'b1);
		chk(fast_speed_flag_out, 1'b1);
		chk(selected_out, 1'b1);
		start(50, 1'b1, sws_pkg::CMD_FAST_MATCH);
		u_mst.send(ROM ^ 64'h8000000000000000, 64, 1'b1);
		chk(fast_speed_flag_out, 1'b1);
		chk(selected_out, 1'b0);
		start(500, 1'b0, sws_pkg::CMD_FAST_MATCH);
		u_mst.send(ROM ^ 64'h0000000000000001, 64, 1'b1);
		chk(fast_speed_flag_out, 1'b0);
		chk(selected_out, 1'b0);
		$display("test fast match done");
	endtask

	// A command outside the set leaves the device deaf until reset
	task t_unknown;
		start(500, 1'b0, 8'h55);
		chk(selected_out, 1'b0);
		rxq.delete();
		u_mst.send(64'h0F, 8, 1'b0);
		chk(rxq.size(), 0);
		$display("test unknown done");
	endtask

	// Main sequence
	initial begin
		rst_b_in = 1'b0;
		tx_en_in = 1'b0;
		tx_bit_in = 1'b0;
		mismatches = 0;
		checks = 0;
		repeat (3) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		t_skip;
		t_fast_skip;
		t_match;
		t_unknown;
		conclude;
	end

	// Watchdog: the run needs about 0.66 ms, so 0.9 ms means a hang
	initial begin
		#900000;
		mismatches++;
		conclude;
	end
endmodule
